// [rtl/channel_arb_pkg.sv]
// Purpose: shared constants and types of one channel's memory arbiter and signature checker
// Assumes: register offsets are the host-visible word addresses of the channel
// Notes: one slot is one system clock; a core clock period is slot setting plus one slots
package channel_arb_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned CM_AW = 10;
  localparam int unsigned DM_AW = 6;
  localparam int unsigned CODE_WORDS = 1023;
  localparam int unsigned DATA_WORDS = 64;
  localparam logic [CM_AW-1:0] CODE_LAST_ADDR = 10'h3fe;
  localparam int unsigned SLOT_W = 4;

  localparam logic [9:0] REG_CODE_LOCK = 10'h100;
  localparam logic [9:0] REG_CODE_LEN = 10'h107;
  localparam logic [9:0] REG_GOLD_HI = 10'h108;
  localparam logic [9:0] REG_GOLD_LO = 10'h109;
  localparam logic [9:0] REG_CLK_DIV = 10'h1a0;

  // code_lock_control fields
  localparam int unsigned LOCK_REQ_BIT = 0;
  localparam int unsigned RUN_EN_BIT = 1;
  localparam int unsigned BYPASS_BIT = 2;
  localparam int unsigned IRQ_EN_BIT = 3;
  localparam int unsigned WARN_BIT = 4;
  localparam int unsigned FAIL_BIT = 5;
  localparam int unsigned DUAL_BIT = 6;

  localparam logic [DW-1:0] CODE_LEN_RESET = 16'h0000;
  localparam logic [DW-1:0] GOLD_RESET = 16'h0000;
  localparam logic [DW-1:0] CLK_DIV_RESET = 16'h0001;
  localparam logic [SLOT_W-1:0] MIN_SLOT_SETTING = 4'h1;

  // worst-case signature time is this many system clocks per word beyond two
  localparam int unsigned SIG_CLKS_PER_WORD = 20;
  localparam int unsigned SIG_WORD_OFFSET = 2;
  localparam int unsigned CLK_PERIOD_NS = 40;

  typedef enum logic [2:0] {
    OWN_NONE = 3'h0,
    OWN_HOST_RW = 3'h1,
    OWN_HOST_RD = 3'h2,
    OWN_CORE0 = 3'h3,
    OWN_CORE1 = 3'h4,
    OWN_SIG = 3'h5
  } owner_t;

  typedef enum logic [1:0] {
    SIG_IDLE = 2'b00,
    SIG_RUN = 2'b01,
    SIG_CHECK = 2'b11,
    SIG_HOLD = 2'b10
  } sig_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [CM_AW-1:0] addr;
    logic [DW-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic ack;
    logic [DW-1:0] rdata;
  } mem_rsp_t;

  // rotate-and-add checksum: order sensitive, so swapped words are caught
  function automatic logic [31:0] sig_step(input logic [31:0] acc, input logic [DW-1:0] word);
    sig_step = {acc[30:0], acc[31]} + {16'h0000, word};
  endfunction
endpackage

// [rtl/slot_sequencer.sv]
// Purpose: time slot counter and per-slot owner of code and data memory
// Assumes: slot setting below one is treated as one
// Notes: owners are combinational from the slot counter flop
`timescale 1ns/1ps
`default_nettype none
module slot_sequencer
  import channel_arb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [SLOT_W-1:0] slot_period_setting,
  input wire logic locked,
  input wire logic dual,
  input wire logic [1:0] cm_want,
  input wire logic [1:0] dm_want,
  output owner_t cm_owner,
  output owner_t dm_owner,
  output logic [SLOT_W-1:0] slot
);
  logic [SLOT_W-1:0] last;

  assign last = (slot_period_setting < MIN_SLOT_SETTING) ? MIN_SLOT_SETTING : slot_period_setting;

  always_ff @(posedge clk) begin
    if (!rstn || slot >= last) begin
      slot <= '0;
    end else begin
      slot <= slot + 4'h1;
    end
  end

  always_comb begin
    if (!locked) begin
      cm_owner = OWN_HOST_RW;
    end else if (slot == 4'h0) begin
      cm_owner = OWN_CORE0;
    end else if (slot == 4'h1) begin
      cm_owner = dual ? OWN_CORE1 : OWN_SIG;
    end else if (slot == 4'h2) begin
      cm_owner = OWN_SIG;
    end else if (slot == 4'h3) begin
      cm_owner = OWN_HOST_RD;
    end else begin
      cm_owner = slot[0] ? OWN_HOST_RD : OWN_SIG;
    end
    if (locked && dual && ((cm_owner == OWN_CORE0 && !cm_want[0]) ||
        (cm_owner == OWN_CORE1 && !cm_want[1]))) begin
      cm_owner = OWN_SIG;
    end
  end

  always_comb begin
    if (!locked) begin
      dm_owner = OWN_HOST_RW;
    end else if (slot == last) begin
      dm_owner = OWN_CORE0;
    end else if (dual && slot == 4'h0) begin
      dm_owner = OWN_CORE1;
    end else begin
      dm_owner = OWN_HOST_RW;
    end
    if (locked && dual && ((dm_owner == OWN_CORE0 && !dm_want[0]) ||
        (dm_owner == OWN_CORE1 && !dm_want[1]))) begin
      dm_owner = OWN_HOST_RW;
    end
  end
endmodule
`default_nettype wire

// [rtl/channel_ram_arbiter_signature.sv]
// Purpose: shared code/data memory arbiter and code signature checker of one channel
// Assumes: host register and memory ports come from the serial interface on clk
// Notes: requests are held until ack; ack and read data follow one clock after the slot
`timescale 1ns/1ps
`default_nettype none
module channel_ram_arbiter_signature
  import channel_arb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  output logic [DW-1:0] reg_rdata,
  input wire mem_req_t host_cm_req,
  output mem_rsp_t host_cm_rsp,
  input wire mem_req_t host_dm_req,
  output mem_rsp_t host_dm_rsp,
  input wire mem_req_t [1:0] core_cm_req,
  output mem_rsp_t [1:0] core_cm_rsp,
  input wire mem_req_t [1:0] core_dm_req,
  output mem_rsp_t [1:0] core_dm_rsp,
  output logic run_enable,
  output logic core_disable,
  output logic signature_warning,
  output logic signature_irq
);
  logic [DW-1:0] code_mem [0:CODE_WORDS-1];
  logic [DW-1:0] data_mem [0:DATA_WORDS-1];

  logic lock_req;
  logic bypass;
  logic irq_en;
  logic dual;
  logic [DW-1:0] code_length_words;
  logic [DW-1:0] golden_signature_high;
  logic [DW-1:0] golden_signature_low;
  logic [DW-1:0] core_clock_divider;

  sig_state_t sig_state;
  logic [CM_AW-1:0] sig_addr;
  logic [31:0] sig_acc;

  owner_t cm_owner;
  owner_t dm_owner;
  logic [1:0] cm_want;
  logic [1:0] dm_want;
  logic host_cm_go;
  logic host_cm_wr;
  logic sig_go;
  logic [CM_AW-1:0] sig_last;
  logic [DW-1:0] lock_view;
  logic host_dm_go;
  logic [1:0] core_dm_go;

  function automatic logic [DW-1:0] cm_read(input logic [CM_AW-1:0] a);
    cm_read = (a <= CODE_LAST_ADDR) ? code_mem[a] : '0;
  endfunction

  function automatic logic [DW-1:0] dm_read(input logic [CM_AW-1:0] a);
    dm_read = data_mem[a[DM_AW-1:0]];
  endfunction

  assign cm_want = {core_cm_req[1].req, core_cm_req[0].req};
  assign dm_want = {core_dm_req[1].req, core_dm_req[0].req};

  slot_sequencer u_seq (
    .clk(clk),
    .rstn(rstn),
    .slot_period_setting(core_clock_divider[SLOT_W-1:0]),
    .locked(lock_req),
    .dual(dual),
    .cm_want(cm_want),
    .dm_want(dm_want),
    .cm_owner(cm_owner),
    .dm_owner(dm_owner),
    .slot()
  );

  // host write to code memory only in full host slots, which exist only while unlocked
  assign host_cm_go = host_cm_req.req &&
                      (cm_owner == OWN_HOST_RW || (cm_owner == OWN_HOST_RD && !host_cm_req.we));
  assign host_cm_wr = host_cm_go && host_cm_req.we && cm_owner == OWN_HOST_RW;
  assign sig_go = (sig_state == SIG_RUN) && (cm_owner == OWN_SIG);
  assign sig_last = code_length_words[CM_AW-1:0] - 10'h001;

  // data memory grants; in dual mode an idle core slot has already been handed to the host
  assign host_dm_go = host_dm_req.req && dm_owner == OWN_HOST_RW;
  assign core_dm_go[0] = core_dm_req[0].req && dm_owner == OWN_CORE0;
  assign core_dm_go[1] = core_dm_req[1].req && dm_owner == OWN_CORE1;

  always_comb begin
    lock_view = '0;
    lock_view[LOCK_REQ_BIT] = lock_req;
    lock_view[RUN_EN_BIT] = run_enable;
    lock_view[BYPASS_BIT] = bypass;
    lock_view[IRQ_EN_BIT] = irq_en;
    lock_view[WARN_BIT] = signature_warning;
    lock_view[FAIL_BIT] = core_disable;
    lock_view[DUAL_BIT] = dual;
  end

  // software-owned configuration
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_req <= 1'b0;
      bypass <= 1'b0;
      irq_en <= 1'b0;
      dual <= 1'b0;
      code_length_words <= CODE_LEN_RESET;
      golden_signature_high <= GOLD_RESET;
      golden_signature_low <= GOLD_RESET;
      core_clock_divider <= CLK_DIV_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CODE_LOCK: begin
          lock_req <= reg_wdata[LOCK_REQ_BIT];
          bypass <= reg_wdata[BYPASS_BIT];
          irq_en <= reg_wdata[IRQ_EN_BIT];
          dual <= reg_wdata[DUAL_BIT];
        end
        REG_CODE_LEN: code_length_words <= reg_wdata;
        REG_GOLD_HI: golden_signature_high <= reg_wdata;
        REG_GOLD_LO: golden_signature_low <= reg_wdata;
        REG_CLK_DIV: core_clock_divider <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CODE_LOCK: reg_rdata <= lock_view;
        REG_CODE_LEN: reg_rdata <= code_length_words;
        REG_GOLD_HI: reg_rdata <= golden_signature_high;
        REG_GOLD_LO: reg_rdata <= golden_signature_low;
        REG_CLK_DIV: reg_rdata <= core_clock_divider;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // signature unit; dropping the lock request aborts it and stops execution
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sig_state <= SIG_IDLE;
      sig_addr <= '0;
      sig_acc <= '0;
      run_enable <= 1'b0;
      core_disable <= 1'b0;
      signature_warning <= 1'b0;
      signature_irq <= 1'b0;
    end else begin
      signature_irq <= 1'b0;
      if (!lock_req) begin
        sig_state <= SIG_IDLE;
        run_enable <= 1'b0;
      end else begin
        unique case (sig_state)
          SIG_IDLE: begin
            sig_addr <= '0;
            sig_acc <= '0;
            core_disable <= 1'b0;
            signature_warning <= 1'b0;
            run_enable <= bypass;
            // an empty code length has nothing to read
            sig_state <= (code_length_words == 16'h0000) ? SIG_CHECK : SIG_RUN;
          end
          SIG_RUN: begin
            // one word per signature slot; without bypass the cores are stopped, so every period has one
            if (sig_go) begin
              sig_acc <= sig_step(sig_acc, cm_read(sig_addr));
              sig_addr <= sig_addr + 10'h001;
              if (sig_addr == sig_last) begin
                sig_state <= SIG_CHECK;
              end
            end
          end
          SIG_CHECK: begin
            sig_state <= SIG_HOLD;
            if (sig_acc == {golden_signature_high, golden_signature_low}) begin
              run_enable <= 1'b1;
            end else if (bypass) begin
              signature_warning <= 1'b1;
            end else begin
              run_enable <= 1'b0;
              core_disable <= 1'b1;
              signature_irq <= irq_en;
            end
          end
          SIG_HOLD: ;
        endcase
      end
    end
  end

  // code memory array writes; no reset so it can map onto a RAM
  always_ff @(posedge clk) begin
    if (host_cm_wr && host_cm_req.addr <= CODE_LAST_ADDR) begin
      code_mem[host_cm_req.addr] <= host_cm_req.wdata;
    end
  end

  // code memory answers, one owner per slot
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_cm_rsp <= '0;
      core_cm_rsp <= '0;
    end else begin
      // while locked the host only reads, and only in its own slots
      host_cm_rsp.ack <= host_cm_go;
      if (host_cm_go) begin
        host_cm_rsp.rdata <= cm_read(host_cm_req.addr);
      end
      for (int i = 0; i < 2; i++) begin
        core_cm_rsp[i].ack <= 1'b0;
      end
      if (cm_owner == OWN_CORE0 && core_cm_req[0].req) begin
        core_cm_rsp[0].ack <= 1'b1;
        core_cm_rsp[0].rdata <= cm_read(core_cm_req[0].addr);
      end
      if (cm_owner == OWN_CORE1 && core_cm_req[1].req) begin
        core_cm_rsp[1].ack <= 1'b1;
        core_cm_rsp[1].rdata <= cm_read(core_cm_req[1].addr);
      end
    end
  end

  // data memory array; the owner of the slot may write
  always_ff @(posedge clk) begin
    if (host_dm_go && host_dm_req.we) begin
      data_mem[host_dm_req.addr[DM_AW-1:0]] <= host_dm_req.wdata;
    end else if (core_dm_go[0] && core_dm_req[0].we) begin
      data_mem[core_dm_req[0].addr[DM_AW-1:0]] <= core_dm_req[0].wdata;
    end else if (core_dm_go[1] && core_dm_req[1].we) begin
      data_mem[core_dm_req[1].addr[DM_AW-1:0]] <= core_dm_req[1].wdata;
    end
  end

  // with setting one in dual mode the host waits for slots left idle by the cores
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_dm_rsp <= '0;
      core_dm_rsp <= '0;
    end else begin
      host_dm_rsp.ack <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        core_dm_rsp[i].ack <= 1'b0;
      end
      unique case (dm_owner)
        OWN_HOST_RW: begin
          // cores holding every data slot starve this; microcode must leave gaps
          if (host_dm_go) begin
            host_dm_rsp.ack <= 1'b1;
            host_dm_rsp.rdata <= dm_read(host_dm_req.addr);
          end
        end
        OWN_CORE0: begin
          if (core_dm_go[0]) begin
            core_dm_rsp[0].ack <= 1'b1;
            core_dm_rsp[0].rdata <= dm_read(core_dm_req[0].addr);
          end
        end
        OWN_CORE1: begin
          if (core_dm_go[1]) begin
            core_dm_rsp[1].ack <= 1'b1;
            core_dm_rsp[1].rdata <= dm_read(core_dm_req[1].addr);
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [dv/channel_arb_asserts.sv]
// Purpose: port properties of the channel arbiter
// Assumes: one clock, synchronous active-low reset
// Notes: slot counter is hidden, so waits use the widest period
`timescale 1ns/1ps
`default_nettype none
module channel_arb_asserts
  import channel_arb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire mem_req_t host_cm_req,
  input wire mem_rsp_t host_cm_rsp,
  input wire mem_req_t [1:0] core_cm_req,
  input wire mem_rsp_t [1:0] core_cm_rsp,
  input wire mem_req_t [1:0] core_dm_req,
  input wire mem_rsp_t [1:0] core_dm_rsp,
  input wire logic run_enable,
  input wire logic core_disable,
  input wire logic signature_warning,
  input wire logic signature_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_lock_off;
    reg_wr && reg_addr == REG_CODE_LOCK && !reg_wdata[LOCK_REQ_BIT];
  endsequence
  sequence s_fetch;
    run_enable && !core_disable && $rose(core_cm_req[0].req);
  endsequence
  sequence s_load;
    run_enable && !core_disable && $rose(core_dm_req[0].req);
  endsequence
  host_ack_pulse_a: assert property (host_cm_rsp.ack |=> !host_cm_rsp.ack)
    else $error("host ack longer than one cycle");
  host_ack_cause_a: assert property (host_cm_rsp.ack |-> $past(host_cm_req.req))
    else $error("host ack without request");
  core_fetch_a: assert property (s_fetch |-> ##[1:17] core_cm_rsp[0].ack)
    else $error("core fetch not served in one period");
  core_load_a: assert property (s_load |-> ##[1:17] core_dm_rsp[0].ack)
    else $error("core data access not served in one period");
  lock_drop_a: assert property (s_lock_off |-> ##[1:2] !run_enable)
    else $error("run enable kept after lock cleared");
  run_fail_a: assert property (!(run_enable && core_disable))
    else $error("run enable and core disable together");
  irq_pulse_a: assert property (signature_irq |=> !signature_irq)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (signature_irq |-> ##[0:1] core_disable)
    else $error("interrupt without core disable");
  warn_only_a: assert property (signature_warning |-> !core_disable)
    else $error("warning with cores disabled");
endmodule
bind channel_ram_arbiter_signature channel_arb_asserts u_chk (
  .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .host_cm_req(host_cm_req), .host_cm_rsp(host_cm_rsp), .core_cm_req(core_cm_req),
  .core_cm_rsp(core_cm_rsp), .core_dm_req(core_dm_req), .core_dm_rsp(core_dm_rsp),
  .run_enable(run_enable), .core_disable(core_disable),
  .signature_warning(signature_warning), .signature_irq(signature_irq));
`default_nettype wire

// [dv/core_pair_model.sv]
// Purpose: two behavioural cores issuing fetches and data accesses
// Assumes: driven at the falling edge, requests held until ack
// Notes: released lines invert each cycle so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module core_pair_model
  import channel_arb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic dual,
  input wire mem_rsp_t [1:0] cm_rsp,
  input wire mem_rsp_t [1:0] dm_rsp,
  output mem_req_t [1:0] cm_req,
  output mem_req_t [1:0] dm_req
);
  initial begin
    cm_req = '0;
    dm_req = '0;
  end
  // sparse issue leaves data slots idle for the host
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (cm_rsp[i].ack || !cm_req[i].req || !rstn) begin
        cm_req[i] <= '{1'b0, 1'b0, ~cm_req[i].addr, ~cm_req[i].wdata};
      end
      if (dm_rsp[i].ack || !dm_req[i].req || !rstn) begin
        dm_req[i] <= '{1'b0, 1'b0, ~dm_req[i].addr, ~dm_req[i].wdata};
      end
      if (rstn && go && (i == 0 || dual) && !cm_req[i].req && $urandom_range(3) == 0) begin
        // fetches stay inside the eight code words that the bench loads
        cm_req[i] <= '{1'b1, 1'b0, 10'($urandom_range(7)), 16'h0000};
      end
      // writes stay in the upper data words that the host leaves alone
      if (rstn && go && (i == 0 || dual) && !dm_req[i].req && $urandom_range(3) == 0) begin
        dm_req[i] <= '{1'b1, 1'($urandom), 10'(48 + $urandom_range(14)), 16'($urandom)};
      end
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: self-checking bench of the channel arbiter and signature unit
// Assumes: inputs change and outputs are sampled at the falling edge, except signature_irq, which is counted at the rising edge
// Notes: code length stays at three words or more, so no bypass is forced
`timescale 1ns/1ps
`default_nettype none
module testbench
  import channel_arb_pkg::*;
;
  localparam int LEN = 8;
  localparam int WAIT = SIG_CLKS_PER_WORD * (LEN - SIG_WORD_OFFSET);
  localparam logic [15:0] LOCK = 16'h0001 << LOCK_REQ_BIT;
  localparam logic [15:0] RUN = 16'h0001 << RUN_EN_BIT;
  localparam logic [15:0] BYP = 16'h0001 << BYPASS_BIT;
  localparam logic [15:0] IRQ = 16'h0001 << IRQ_EN_BIT;
  localparam logic [15:0] WARN = 16'h0001 << WARN_BIT;
  localparam logic [15:0] DUAL = 16'h0001 << DUAL_BIT;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [DW-1:0] reg_wdata = 16'h0000;
  logic [DW-1:0] reg_rdata;
  logic [DW-1:0] r;
  logic [DW-1:0] w;
  logic [DW-1:0] code [LEN];
  mem_req_t host_cm_req = '0;
  mem_req_t host_dm_req = '0;
  mem_rsp_t host_cm_rsp;
  mem_rsp_t host_dm_rsp;
  mem_req_t [1:0] core_cm_req;
  mem_req_t [1:0] core_dm_req;
  mem_rsp_t [1:0] core_cm_rsp;
  mem_rsp_t [1:0] core_dm_rsp;
  logic run_enable;
  logic core_disable;
  logic signature_warning;
  logic signature_irq;
  logic core_en = 1'b0;
  logic dual = 1'b0;
  int mismatches = 0;
  int checks = 0;
  int irqs = 0;
  logic [9:0] regs [6] = '{REG_CODE_LOCK, REG_CODE_LEN, REG_GOLD_HI, REG_GOLD_LO,
    REG_CLK_DIV, 10'h1ff};
  logic [3:0] sets [4] = '{4'h1, 4'h2, 4'h3, 4'hf};

  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) if (signature_irq === 1'b1) irqs++;
  // core fetch data is taken while the ack stands, request still held
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (core_cm_rsp[i].ack === 1'b1) begin
        chk("core fetch", code[core_cm_req[i].addr[2:0]], core_cm_rsp[i].rdata);
      end
    end
  end

  channel_ram_arbiter_signature u_dut (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_cm_req(host_cm_req),
    .host_cm_rsp(host_cm_rsp), .host_dm_req(host_dm_req), .host_dm_rsp(host_dm_rsp),
    .core_cm_req(core_cm_req), .core_cm_rsp(core_cm_rsp), .core_dm_req(core_dm_req),
    .core_dm_rsp(core_dm_rsp), .run_enable(run_enable), .core_disable(core_disable),
    .signature_warning(signature_warning), .signature_irq(signature_irq));
  core_pair_model u_cores (
    .clk(clk), .rstn(rstn), .go(core_en & run_enable), .dual(dual),
    .cm_rsp(core_cm_rsp), .dm_rsp(core_dm_rsp), .cm_req(core_cm_req), .dm_req(core_dm_req));

  task automatic complete_run();
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  // strobes drop for a cycle so back-to-back calls never rewrite them in one step
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [9:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    r = reg_rdata;
  endtask
  task automatic mem(input bit d, input logic we, input logic [9:0] a, input logic [15:0] v);
    int n;
    n = 0;
    if (d) host_dm_req = '{1'b1, we, a, v};
    else host_cm_req = '{1'b1, we, a, v};
    do begin
      @(negedge clk);
      n++;
    end while ((d ? host_dm_rsp.ack : host_cm_rsp.ack) !== 1'b1 && n < 300);
    r = d ? host_dm_rsp.rdata : host_cm_rsp.rdata;
    if (d) host_dm_req = '{1'b0, ~we, ~a, ~v};
    else host_cm_req = '{1'b0, ~we, ~a, ~v};
    chk("host wait", 1, n < 300);
    @(negedge clk);
  endtask
  function automatic logic [31:0] csum();
    logic [31:0] a;
    a = 32'h0;
    for (int i = 0; i < LEN; i++) a = {a[30:0], a[31]} + {16'h0000, code[i]};
    return a;
  endfunction
  task automatic sig(input logic [15:0] m, input logic [31:0] g);
    int n;
    n = 0;
    wr(REG_GOLD_HI, g[31:16]);
    wr(REG_GOLD_LO, g[15:0]);
    wr(REG_CODE_LOCK, m | LOCK);
    if (m & BYP) chk("bypass run", 1, run_enable);
    while (!(run_enable && !(m & BYP)) && !core_disable && !signature_warning && n < WAIT) begin
      @(negedge clk);
      n++;
    end
    chk("signature time", 1, n < WAIT);
  endtask

  initial begin
    #(CLK_PERIOD_NS * 60000);
    mismatches++;
    complete_run();
  end
  initial begin
    void'($urandom(59));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(regs[i]);
      chk("reg reset", regs[i] == REG_CLK_DIV ? CLK_DIV_RESET : 16'h0000, r);
    end
    wr(10'h1ff, 16'hffff);
    rd(10'h1ff);
    chk("unmapped", 0, r);
    wr(REG_CODE_LEN, 16'(LEN));
    rd(REG_CODE_LEN);
    chk("length", LEN, r);
    for (int i = 0; i < LEN; i++) begin
      code[i] = 16'($urandom);
      mem(0, 1, 10'(i), code[i]);
    end
    mem(0, 1, 10'h3ff, 16'hffff);
    mem(0, 0, 10'h3ff, 16'h0000);
    chk("code top", 0, r);
    for (int c = 0; c < 8; c++) begin
      dual = c[0];
      wr(REG_CLK_DIV, {12'h000, sets[c / 2]});
      sig(dual ? DUAL : 16'h0000, csum());
      chk("run", 1, run_enable);
      chk("disable", 0, core_disable);
      core_en = 1'b1;
      for (int i = 0; i < 3 && sets[c / 2] > 2; i++) begin
        w = 16'($urandom_range(LEN - 1));
        mem(0, 0, 10'(w), 16'h0000);
        chk("code read", code[w], r);
      end
      w = 16'($urandom);
      mem(1, 1, 10'(c * 4 + 3), w);
      mem(1, 0, 10'(c * 4 + 3), 16'h0000);
      chk("data", w, r);
      core_en = 1'b0;
      repeat (40) @(negedge clk);
      wr(REG_CODE_LOCK, 16'h0000);
      chk("unlock run", 0, run_enable);
    end
    dual = 1'b0;
    sig(IRQ, ~csum());
    chk("fail disable", 1, core_disable);
    chk("fail run", 0, run_enable);
    // the pulse is counted at the next rising edge
    @(negedge clk);
    chk("fail irq", 1, irqs);
    wr(REG_CODE_LOCK, 16'h0000);
    sig(BYP | IRQ, ~csum());
    chk("warn", 1, signature_warning);
    chk("warn run", 1, run_enable);
    chk("warn disable", 0, core_disable);
    chk("warn irq", 1, irqs);
    rd(REG_CODE_LOCK);
    chk("lock view", LOCK | RUN | BYP | IRQ | WARN, r);
    complete_run();
  end
endmodule
`default_nettype wire
